// File: src/tas_pkg.sv
`default_nettype none
package tas_pkg;
  // Alarm conditions, highest priority has lowest nonzero code
  typedef enum logic [2:0] {
    TAS_NONE = 3'b000, TAS_LOS = 3'b001, TAS_LOF = 3'b010, TAS_AIS = 3'b011,
    TAS_OOF = 3'b100, TAS_EER = 3'b101, TAS_YEL = 3'b110
  } tas_cond_e;
  typedef enum logic [1:0] {
    TAS_CALL_IDLE = 2'b00, TAS_CALL_DIAL = 2'b01, TAS_CALL_WAIT = 2'b10, TAS_CALL_UP = 2'b11
  } tas_call_e;
  // Register map
  localparam logic [7:0] TAS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TAS_STATUS_OFS = 8'h04;
  localparam logic [7:0] TAS_MSG_OFS    = 8'h08;
  localparam logic [7:0] TAS_CMD_OFS    = 8'h0C;
  localparam logic [31:0] TAS_CTRL_RST  = 32'h0000_1400;
  // Control fields
  localparam int TAS_ROUTE_LSB = 0;
  localparam int TAS_TRAP_BIT  = 2;
  localparam int TAS_HANG_BIT  = 3;
  localparam int TAS_DIAL_BIT  = 4;
  localparam int TAS_RETRY_BIT = 5;
  localparam int TAS_RELAY_BIT = 6;
  localparam int TAS_ALT_LSB   = 7;
  localparam int TAS_DLY_LSB   = 10;
  localparam int TAS_RATE_LSB  = 14;
  localparam int TAS_CUSTOMER_BIT = 17;
  // Command bits
  localparam int TAS_CMD_CUTOFF = 0;
  // Timing
  localparam longint TAS_CLK_HZ     = 20_000_000;
  localparam longint TAS_MINUTE_S   = 60;
  localparam longint TAS_SEC_CYCLES = TAS_CLK_HZ;
  localparam int TAS_RETRY_MAX  = 5;
  localparam int TAS_TRAP_DEPTH = 10;
  localparam logic [3:0] TAS_DLY_DEF = 4'h5;
  // Error rate windows in seconds and thresholds
  localparam logic [10:0] TAS_WIN4_S  = 11'h00A;
  localparam logic [10:0] TAS_WIN60_S = 11'h03C;
  localparam logic [10:0] TAS_WIN15M_S = 11'h384;
  localparam logic [10:0] TAS_THR4 = 11'd1535;
  localparam logic [10:0] TAS_THR5 = 11'd921;
  localparam logic [10:0] TAS_THR6 = 11'd92;
  localparam logic [10:0] TAS_THR7 = 11'd9;
  localparam logic [10:0] TAS_THR8 = 11'd41;
  localparam logic [10:0] TAS_THR9 = 11'd4;
endpackage
`default_nettype wire

// File: src/tas_top.sv
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`default_nettype none
module tas_top import tas_pkg::*; #(
  parameter longint SEC_CYCLES = TAS_SEC_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Framer conditions, index 0 network, 1 DTE
  input  wire logic [1:0]  los_in,
  input  wire logic [1:0]  lof_in,
  input  wire logic [1:0]  ais_in,
  input  wire logic [1:0]  oof_in,
  input  wire logic [1:0]  yel_in,
  input  wire logic        crc6_err,
  // Port use and state
  input  wire logic        modem_ascii,
  input  wire logic        com_ascii,
  input  wire logic        modem_term_idle,
  input  wire logic        com_term_idle,
  input  wire logic        modem_mgmt,
  input  wire logic        com_mgmt,
  // Message ports
  output logic [5:0]       msg_data,
  output logic             modem_msg_valid,
  output logic             com_msg_valid,
  // Traps
  input  wire logic        trap_req,
  output logic             trap_send,
  output logic [3:0]       trap_level,
  // Modem dialer
  input  wire logic        modem_connected,
  input  wire logic        call_failed,
  output logic             dial_start,
  output logic             dial_alternate,
  output logic             hangup,
  // Relay
  output logic             relay_on
);
  // ---------------------------------------------------------------
  // Registers and bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic        aw_q, w_q, ar_q;
  logic [7:0]  awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic        cutoff_q;
  wire do_wr   = aw_q && w_q && !s_axi_bvalid;
  wire wr_ctrl = do_wr && (awaddr_q == TAS_CTRL_OFS);
  wire wr_cmd  = do_wr && (awaddr_q == TAS_CMD_OFS);
  wire wr_ok   = (awaddr_q == TAS_CTRL_OFS) || (awaddr_q == TAS_CMD_OFS);
  wire [1:0] route   = ctrl_q[TAS_ROUTE_LSB +: 2];
  wire       trap_en = ctrl_q[TAS_TRAP_BIT];
  wire       hang_en = ctrl_q[TAS_HANG_BIT];
  wire       dial_en = ctrl_q[TAS_DIAL_BIT];
  wire       retry_en = ctrl_q[TAS_RETRY_BIT];
  wire       relay_en = ctrl_q[TAS_RELAY_BIT];
  wire [2:0] alt_dir = ctrl_q[TAS_ALT_LSB +: 3];
  wire [3:0] dly_raw = ctrl_q[TAS_DLY_LSB +: 4];
  wire [3:0] dly_min = (dly_raw == 4'h0) ? 4'h1 : (dly_raw > 4'hA) ? 4'hA : dly_raw;
  wire [2:0] rate_sel = ctrl_q[TAS_RATE_LSB +: 3];
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 8'h00; wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
      ctrl_q <= TAS_CTRL_RST;
      cutoff_q <= 1'b0;
    end else begin
      cutoff_q <= wr_cmd && wdata_q[TAS_CMD_CUTOFF];
      if (s_axi_awvalid && s_axi_awready) begin aw_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1; wdata_q <= (s_axi_wdata & wmask) | (ctrl_q & ~wmask);
      end
      if (do_wr) begin
        aw_q <= 1'b0; w_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        if (wr_ctrl) ctrl_q <= wdata_q;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_q && !s_axi_wready && s_axi_wvalid;
      s_axi_arready <= !ar_q && !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
    end
  end
  // ---------------------------------------------------------------
  // Alarm resolution
  // ---------------------------------------------------------------
  logic      eer_q;
  tas_cond_e cond_q;
  logic      iface_q;
  tas_cond_e cond_d;
  logic      iface_d;
  always_comb begin
    cond_d = TAS_NONE; iface_d = 1'b0;
    if (|los_in) begin cond_d = TAS_LOS; iface_d = !los_in[0]; end
    else if (|lof_in) begin cond_d = TAS_LOF; iface_d = !lof_in[0]; end
    else if (|ais_in) begin cond_d = TAS_AIS; iface_d = !ais_in[0]; end
    else if (|oof_in) begin cond_d = TAS_OOF; iface_d = !oof_in[0]; end
    else if (eer_q) begin cond_d = TAS_EER; iface_d = 1'b0; end
    else if (|yel_in) begin cond_d = TAS_YEL; iface_d = !yel_in[0]; end
  end
  wire       chg   = (cond_d != cond_q) || (iface_d != iface_q);
  wire [5:0] clr_msg = {ctrl_q[TAS_CUSTOMER_BIT], 1'b0, cond_q, iface_q};
  wire [5:0] set_msg = {ctrl_q[TAS_CUSTOMER_BIT], 1'b1, cond_d, iface_d};
  // ---------------------------------------------------------------
  // Message routing
  // ---------------------------------------------------------------
  logic       set_pend_q;
  logic [5:0] pend_q;
  logic       pend_v_q;
  wire com_ok   = route[1] && com_ascii && com_term_idle && !com_mgmt;
  wire modem_rt = route[0] && modem_ascii && modem_term_idle && !modem_mgmt;
  logic [5:0] ev_msg;
  logic       ev_v;
  always_comb begin
    ev_v = 1'b0; ev_msg = set_msg;
    if (set_pend_q) begin ev_v = 1'b1; ev_msg = {ctrl_q[TAS_CUSTOMER_BIT], 1'b1, cond_q, iface_q}; end
    else if (chg && cond_q != TAS_NONE) begin ev_v = 1'b1; ev_msg = clr_msg; end
    else if (chg) begin ev_v = 1'b1; ev_msg = set_msg; end
  end
  // ---------------------------------------------------------------
  // Dialer
  // ---------------------------------------------------------------
  tas_call_e  call_q;
  logic [2:0] tries_q;
  logic       alt_q;
  logic [3:0] min_q;
  logic [5:0] dsec_q;
  logic [31:0] tick_q;
  logic [31:0] dtick_q;
  logic       trap_call_q;
  logic [3:0] trap_cnt_q;
  wire sec_tick  = (tick_q == 32'(SEC_CYCLES - 1));
  wire dsec_tick = (dtick_q == 32'(SEC_CYCLES - 1));
  wire dmin_tick = dsec_tick && (dsec_q == 6'(TAS_MINUTE_S - 1));
  wire hang_now  = trap_call_q && hang_en && (trap_cnt_q == 4'h0);
  wire up_end    = (call_q == TAS_CALL_UP) && (hang_now || !modem_connected);
  wire dly_load  = up_end || ((call_q == TAS_CALL_DIAL) && !modem_connected && call_failed);
  // dial only when enabled and unconnected
  wire need_call = dial_en && !modem_connected;
  // queue up to ten traps while the modem or COM port is in management use
  wire trap_push = trap_req && trap_en && (modem_mgmt || com_mgmt) && (trap_cnt_q != 4'(TAS_TRAP_DEPTH));
  wire trap_ready = (trap_cnt_q != 4'h0) && (com_mgmt || modem_connected);
  wire pend_take = ev_v && modem_rt && need_call &&
                   (!pend_v_q || (ev_msg[3:1] != 3'b000 && ev_msg[3:1] < pend_q[3:1]));
  wire tries_done = (tries_q == 3'(TAS_RETRY_MAX + 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_q <= TAS_NONE; iface_q <= 1'b0; set_pend_q <= 1'b0;
      msg_data <= 6'h00; modem_msg_valid <= 1'b0; com_msg_valid <= 1'b0;
      pend_q <= 6'h00; pend_v_q <= 1'b0;
    end else begin
      cond_q <= cond_d; iface_q <= iface_d;
      set_pend_q <= chg && cond_q != TAS_NONE && cond_d != TAS_NONE;
      msg_data <= ev_msg;
      com_msg_valid <= ev_v && com_ok;
      modem_msg_valid <= 1'b0;
      if (ev_v && modem_rt && modem_connected) modem_msg_valid <= 1'b1;
      else if (pend_v_q && modem_connected && call_q == TAS_CALL_UP) begin
        modem_msg_valid <= 1'b1; msg_data <= pend_q; pend_v_q <= 1'b0;
      end
      if (pend_take) begin pend_q <= ev_msg; pend_v_q <= 1'b1; end
      else if (call_q == TAS_CALL_IDLE && pend_v_q && !modem_connected && tries_done) pend_v_q <= 1'b0;
      else if (!dial_en) pend_v_q <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 32'h0000_0000;
    end else begin
      tick_q <= sec_tick ? 32'h0000_0000 : tick_q + 32'h0000_0001;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      call_q <= TAS_CALL_IDLE; tries_q <= 3'h0; alt_q <= 1'b0; min_q <= 4'h0;
      dial_start <= 1'b0; dial_alternate <= 1'b0; hangup <= 1'b0; trap_call_q <= 1'b0;
      dtick_q <= 32'h0000_0000; dsec_q <= 6'h00;
    end else begin
      dial_start <= 1'b0; hangup <= 1'b0;
      dtick_q <= (dly_load || dsec_tick) ? 32'h0000_0000 : dtick_q + 32'h0000_0001;
      if (dly_load) dsec_q <= 6'h00;
      else if (dsec_tick) dsec_q <= dmin_tick ? 6'h00 : dsec_q + 6'h01;
      if (dmin_tick && min_q != 4'h0) min_q <= min_q - 4'h1;
      case (call_q)
        TAS_CALL_IDLE: begin
          if ((pend_v_q || (trap_cnt_q != 4'h0 && modem_mgmt)) && need_call && min_q == 4'h0 && !tries_done) begin
            call_q <= TAS_CALL_DIAL; dial_start <= 1'b1; dial_alternate <= alt_q;
            trap_call_q <= !pend_v_q;
          end
        end
        TAS_CALL_DIAL: begin
          if (modem_connected) call_q <= TAS_CALL_UP;
          else if (call_failed) begin
            min_q <= dly_min;
            call_q <= TAS_CALL_WAIT;
            if (!retry_en) tries_q <= 3'(TAS_RETRY_MAX + 1);
            else if (tries_q == 3'(TAS_RETRY_MAX) && !alt_q && alt_dir != 3'h0) begin
              alt_q <= 1'b1; tries_q <= 3'h0;
            end else tries_q <= tries_q + 3'h1;
          end
        end
        TAS_CALL_WAIT: if (min_q == 4'h0) call_q <= TAS_CALL_IDLE;
        TAS_CALL_UP: begin
          if (hang_now) hangup <= 1'b1;
          if (up_end) begin call_q <= TAS_CALL_IDLE; tries_q <= 3'h0; alt_q <= 1'b0; min_q <= dly_min; end
        end
        default: call_q <= TAS_CALL_IDLE;
      endcase
      if (call_q == TAS_CALL_IDLE && tries_done && !pend_v_q && trap_cnt_q == 4'h0) begin
        tries_q <= 3'h0; alt_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_cnt_q <= 4'h0; trap_send <= 1'b0; trap_level <= 4'h0;
    end else begin
      trap_send <= trap_ready && trap_en;
      if (!trap_en) trap_cnt_q <= 4'h0;
      else if (trap_push && !trap_ready) trap_cnt_q <= trap_cnt_q + 4'h1;
      else if (!trap_push && trap_ready) trap_cnt_q <= trap_cnt_q - 4'h1;
      else if (call_q == TAS_CALL_IDLE && tries_done && modem_mgmt) trap_cnt_q <= 4'h0;
      trap_level <= trap_cnt_q;
    end
  end
  // ---------------------------------------------------------------
  // Error rate
  // ---------------------------------------------------------------
  logic [10:0] err_q;
  logic [10:0] win_sec_q;
  logic [1:0]  ivl_q;
  wire [10:0] win_len = (rate_sel == 3'h0) ? TAS_WIN4_S : (rate_sel < 3'h4) ? TAS_WIN60_S : TAS_WIN15M_S;
  wire [10:0] thr = (rate_sel == 3'h0) ? TAS_THR4 : (rate_sel == 3'h1) ? TAS_THR5 :
                    (rate_sel == 3'h2) ? TAS_THR6 : (rate_sel == 3'h3) ? TAS_THR7 :
                    (rate_sel == 3'h4) ? TAS_THR8 : TAS_THR9;
  wire win_end = sec_tick && (win_sec_q >= win_len - 11'h001);
  wire long_win = rate_sel >= 3'h4;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_q <= 11'h000; win_sec_q <= 11'h000; ivl_q <= 2'h0; eer_q <= 1'b0;
    end else begin
      if (sec_tick) win_sec_q <= win_end ? 11'h000 : win_sec_q + 11'h001;
      if (long_win && win_end) ivl_q <= (ivl_q == 2'h2) ? 2'h0 : ivl_q + 2'h1;
      if (win_end && (!long_win || ivl_q == 2'h2)) begin
        err_q <= {10'h000, crc6_err};
        eer_q <= err_q > thr;
      end else if (crc6_err && err_q != 11'h7FF) err_q <= err_q + 11'h001;
    end
  end
  // ---------------------------------------------------------------
  // Relay
  // ---------------------------------------------------------------
  logic lock_q;
  wire relay_cause = (|los_in) || (|oof_in) || (|ais_in) || (|yel_in) || eer_q;
  wire any_alarm = relay_cause || (|lof_in);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_on <= 1'b0; lock_q <= 1'b0;
    end else begin
      if (cutoff_q) lock_q <= 1'b1;
      else if (!any_alarm) lock_q <= 1'b0;
      relay_on <= relay_en && relay_cause && !lock_q && !cutoff_q;
    end
  end
  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [31:0] status = {14'h0000, trap_cnt_q, tries_q, alt_q, call_q, lock_q, relay_on, eer_q, iface_q, cond_q, pend_v_q};
  wire [31:0] rd_val = (araddr_q == TAS_CTRL_OFS) ? ctrl_q : (araddr_q == TAS_STATUS_OFS) ? status :
                       (araddr_q == TAS_MSG_OFS) ? {26'h0000000, pend_q} : 32'h0000_0000;
  wire rd_ok = (araddr_q == TAS_CTRL_OFS) || (araddr_q == TAS_STATUS_OFS) || (araddr_q == TAS_MSG_OFS) ||
               (araddr_q == TAS_CMD_OFS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 1'b0; araddr_q <= 8'h00; s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin ar_q <= 1'b1; araddr_q <= s_axi_araddr; end
      if (ar_q && !s_axi_rvalid) begin
        ar_q <= 1'b0; s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_val; s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/t1_alarm_supervisor_tb.sv
`default_nettype none
module t1_alarm_supervisor_tb import tas_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam longint     SEC = 40;
  localparam int         MIN_CYC = 60 * SEC;
  localparam logic [4:0] RLY [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
  logic        aclk = 1'b0, aresetn = 1'b0, crc6_err = 1'b0, trap_req = 1'b0, fail_mode = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, com_mgmt = 1'b0, com_ascii = 1'b1;
  logic        modem_mgmt = 1'b0, modem_ascii = 1'b1, modem_term_idle = 1'b1, com_term_idle = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, trap_level;
  logic [1:0]  los_in = 2'h0, lof_in = 2'h0, ais_in = 2'h0, oof_in = 2'h0, yel_in = 2'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  msg_data, last_msg;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        modem_msg_valid, com_msg_valid, trap_send, modem_connected, call_failed;
  logic        dial_start, dial_alternate, hangup, relay_on;
  int          num_errors = 0, samples_checked = 0, com_cnt = 0, modem_cnt = 0;
  tas_top #(.SEC_CYCLES(SEC)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .los_in, .lof_in, .ais_in, .oof_in, .yel_in, .crc6_err, .modem_ascii, .com_ascii, .modem_term_idle,
    .com_term_idle, .modem_mgmt, .com_mgmt, .msg_data, .modem_msg_valid, .com_msg_valid, .trap_req,
    .trap_send, .trap_level, .modem_connected, .call_failed, .dial_start, .dial_alternate, .hangup, .relay_on);
  tas_partner dlr_u (.aclk, .aresetn, .dial_start, .dial_alternate, .hangup, .fail_mode, .modem_connected,
    .call_failed);
  always #25 aclk = ~aclk;
  always @(posedge aclk) begin
    if (com_msg_valid === 1'b1 || modem_msg_valid === 1'b1) last_msg <= msg_data;
    com_cnt <= com_cnt + (com_msg_valid === 1'b1);
    modem_cnt <= modem_cnt + (modem_msg_valid === 1'b1);
  end
  // ----------------------------------------
  // Bench helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if ((wr ? s_axi_bvalid : s_axi_rvalid) === 1'b1) break;
    end
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
    {s_axi_bready, s_axi_rready} <= 2'b00;
    chk("bus answer", 1, n < 100);
    if (n == 100) final_report();
  endtask
  task automatic drive(input logic [4:0] v, input logic f);
    @(posedge aclk);
    los_in <= {v[0] & f, v[0] & !f};
    lof_in <= {v[1] & f, v[1] & !f};
    ais_in <= {v[2] & f, v[2] & !f};
    oof_in <= {v[3] & f, v[3] & !f};
    yel_in <= {v[4] & f, v[4] & !f};
  endtask
  function automatic logic [2:0] top_cond(input logic [4:0] v);
    for (int i = 0; i < 5; i++) if (v[i]) return (i == 4) ? 3'h6 : 3'(i + 1);
    return 3'h0;
  endfunction
  task automatic expect_msg(input string nm, input logic [5:0] e, input int lim);
    int goal;
    int n;
    goal = com_cnt + modem_cnt + 1;
    for (n = 0; n < lim && com_cnt + modem_cnt < goal; n++) @(posedge aclk);
    chk(nm, e, (n < lim) ? last_msg : ~e);
    if (n == lim) final_report();
  endtask
  task automatic wait_relay(input logic lvl);
    int n;
    for (n = 0; n < 60 && relay_on !== lvl; n++) @(posedge aclk);
    chk("relay_on", lvl, relay_on);
    if (n == 60) final_report();
  endtask
  task automatic pulse(input logic sel, input int cnt);
    repeat (cnt) begin
      @(posedge aclk);
      {crc6_err, trap_req} <= sel ? 2'b10 : 2'b01;
      @(posedge aclk);
      {crc6_err, trap_req} <= 2'b00;
    end
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [4:0]  v;
    logic        f;
    int          b;
    int          n;
    d = $urandom(95);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi(1'b0, TAS_CTRL_OFS, 32'h0, d, r);
    chk("ctrl reset", TAS_CTRL_RST, d);
    axi(1'b0, 8'h10, 32'h0, d, r);
    chk("unmapped", 32'h2, {d[29:0], r});
    axi(1'b1, TAS_CTRL_OFS, 32'h0002_0402, d, r);
    chk("write resp", 32'h0, r);
    for (int k = 0; k < 10; k++) begin
      v = (k == 0) ? 5'h1F : 5'($urandom_range(31, 1));
      f = 1'($urandom);
      drive(v, f);
      expect_msg("set msg", {2'b11, top_cond(v), f}, 60);
      drive(5'h00, 1'b0);
      expect_msg("clear msg", {2'b10, top_cond(v), f}, 60);
    end
    for (int i = 0; i < 16; i++) begin
      com_mgmt <= i[2];
      com_ascii <= i[3];
      axi(1'b1, TAS_CTRL_OFS, 32'h0002_0400 | 32'(i & 3), d, r);
      b = com_cnt;
      drive(5'h08, 1'b0);
      repeat (40) @(posedge aclk);
      drive(5'h00, 1'b0);
      repeat (40) @(posedge aclk);
      chk("com count", ((i & 14) == 10) ? 2 : 0, com_cnt - b);
    end
    chk("modem discard", 0, modem_cnt);
    com_mgmt <= 1'b0;
    com_ascii <= 1'b1;
    axi(1'b1, TAS_CTRL_OFS, 32'h0000_0440, d, r);
    for (int k = 0; k < 4; k++) begin
      drive(RLY[k], 1'($urandom));
      wait_relay(1'b1);
      drive(5'h00, 1'b0);
      wait_relay(1'b0);
    end
    drive(5'h01, 1'b1);
    wait_relay(1'b1);
    axi(1'b1, TAS_CMD_OFS, 32'h0000_0001, d, r);
    wait_relay(1'b0);
    repeat (20) @(posedge aclk);
    chk("relay after cut-off", 0, relay_on);
    drive(5'h00, 1'b0);
    repeat (5) @(posedge aclk);
    drive(5'h01, 1'b1);
    wait_relay(1'b1);
    drive(5'h00, 1'b0);
    axi(1'b1, TAS_CTRL_OFS, 32'h0002_C402, d, r);
    b = com_cnt;
    pulse(1'b1, 9);
    repeat (3 * MIN_CYC) @(posedge aclk);
    chk("rate at limit", b, com_cnt);
    pulse(1'b1, 20 + $urandom_range(20));
    expect_msg("rate set", 6'h3A, 3 * MIN_CYC);
    expect_msg("rate clear", 6'h2A, 3 * MIN_CYC);
    axi(1'b1, TAS_CTRL_OFS, 32'h0002_0411, d, r);
    drive(5'h01, 1'b0);
    expect_msg("modem set", 6'h32, 3 * MIN_CYC);
    drive(5'h00, 1'b0);
    expect_msg("modem clear", 6'h22, 60);
    fail_mode <= 1'b1;
    axi(1'b1, TAS_CTRL_OFS, 32'h0002_04B1, d, r);
    drive(5'h02, 1'b1);
    for (int k = 0; k < 13; k++) begin
      for (n = 0; n < 3 * MIN_CYC && dial_start !== 1'b1; n++) @(posedge aclk);
      if (k == 12) begin
        chk("dial count", 3 * MIN_CYC, n);
      end else begin
        chk("dial alternate", k > 5, dial_alternate);
        chk("dial gap", 1, k == 0 || n >= MIN_CYC - 2);
        if (n == 3 * MIN_CYC) final_report();
        @(posedge aclk);
      end
    end
    axi(1'b1, TAS_CTRL_OFS, 32'h0000_0400, d, r);
    drive(5'h00, 1'b0);
    modem_mgmt <= 1'b1;
    pulse(1'b0, 3);
    repeat (5) @(posedge aclk);
    chk("trap off", 0, {trap_send, trap_level});
    axi(1'b1, TAS_CTRL_OFS, 32'h0000_0404, d, r);
    pulse(1'b0, 12);
    repeat (5) @(posedge aclk);
    chk("trap queue", TAS_TRAP_DEPTH, trap_level);
    fail_mode <= 1'b0;
    axi(1'b1, TAS_CTRL_OFS, 32'h0000_041C, d, r);
    for (n = 0; n < 3 * MIN_CYC && hangup !== 1'b1; n++) @(posedge aclk);
    chk("trap hangup", 0, {n == 3 * MIN_CYC, trap_level});
    final_report();
  end
endmodule
bind tas_top tas_asserts #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .com_ascii, .com_term_idle, .com_mgmt, .msg_data,
  .modem_msg_valid, .com_msg_valid, .trap_send, .trap_level, .modem_connected, .dial_start, .relay_on);
`default_nettype wire

// File: verif/tas_asserts.sv
`default_nettype none
module tas_asserts import tas_pkg::*; #(
  parameter longint SEC_CYCLES = TAS_SEC_CYCLES
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Port state and messages
  input wire logic        com_ascii,
  input wire logic        com_term_idle,
  input wire logic        com_mgmt,
  input wire logic [5:0]  msg_data,
  input wire logic        modem_msg_valid,
  input wire logic        com_msg_valid,
  // Traps, dialer and relay
  input wire logic        trap_send,
  input wire logic [3:0]  trap_level,
  input wire logic        modem_connected,
  input wire logic        dial_start,
  input wire logic        relay_on
);
  // ----------------------------------------
  // Checks on the block outputs
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  chk_bvalid_holds: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_holds: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_reset_quiet: assert property (
    $rose(aresetn) |-> !(relay_on || dial_start || trap_send || modem_msg_valid || com_msg_valid))
    else $error("output active right after reset");
  chk_msg_cond: assert property (
    (modem_msg_valid || com_msg_valid) |-> msg_data[3:1] inside {[3'h1:3'h6]})
    else $error("message carries no alarm condition");
  chk_com_gate: assert property (
    com_msg_valid |-> $past(com_ascii && com_term_idle && !com_mgmt))
    else $error("message sent to a port that is not free");
  chk_trap_depth: assert property (trap_level <= 4'hA)
    else $error("trap queue above ten");
  chk_trap_queued: assert property (trap_send |-> trap_level != 4'h0)
    else $error("trap sent with empty queue");
  chk_dial_idle: assert property (dial_start |-> !$past(modem_connected))
    else $error("dial while connected");
  chk_dial_gap: assert property (dial_start |=> !dial_start [*8])
    else $error("dial attempts too close");
endmodule
`default_nettype wire

// File: verif/tas_partner.sv
`default_nettype none
module tas_partner (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Dialer control
  input  wire logic dial_start,
  input  wire logic dial_alternate,
  input  wire logic hangup,
  input  wire logic fail_mode,
  output logic      modem_connected,
  output logic      call_failed
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Modem dialer model
  // ----------------------------------------
  int wait_q = 0;
  always @(posedge aclk) begin
    call_failed <= 1'b0;
    if (!aresetn || hangup || fail_mode) modem_connected <= 1'b0;
    wait_q <= !aresetn ? 0 : dial_start ? (dial_alternate ? 3 : 9) : (wait_q > 0 ? wait_q - 1 : 0);
    if (aresetn && wait_q == 1) begin
      modem_connected <= !fail_mode;
      call_failed <= fail_mode;
    end
  end
endmodule
`default_nettype wire
